//--- design/ict_timer.sv
// three channel interval counter timer with apb register access
//
// Local design decisions: the APB register port and the register offsets.
`include "ict_defines.svh"
module ict_timer
	import ict_pkg::*;
(
	input wire logic clock, // 200 MHz system clock
	input wire logic reset, // async reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic clk0_ext, // external clock for counter zero
	input wire logic clk1_in, // clock pin of counter one
	input wire logic [2:0] gate_in, // gate pins of the three counters
	output logic [2:0] cnt_out, // counter outputs
	output logic ad_start // one-cycle conversion start pulse
);

	// ************************************************
	// constants and state
	// ************************************************
	localparam logic [4:0] HALF_M1 =
		5'((`ICT_INT_PERIOD_NS / `ICT_SYS_PERIOD_NS) / 2 - 1);

	ict_state_t s_ff;
	ict_state_t nxt_s;
	logic [4:0] sy;
	logic [2:0] src;
	logic [2:0] gate;
	logic [2:0] tick;
	logic [2:0] rise;
	logic acc;
	logic done;
	logic wr_cyc;
	logic ctr_hit;
	logic ctrl_hit;
	logic cs_hit;
	logic [1:0] cid;

	// decrement by one, binary or four bcd digits
	function automatic logic [15:0] ict_dec(input logic [15:0] v, input logic b);
		logic [15:0] r;
		logic brw;
		r = v;
		brw = 1'b1;
		if (!b)
			r = v - `ICT_CNT_ONE;
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (brw)
				begin
					if (r[k*4 +: 4] == 4'h0)
						r[k*4 +: 4] = `ICT_BCD_MAX;
					else
					begin
						r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// ************************************************
	// pin synchronisers and event detection
	// ************************************************
	ict_sync #(.W(5)) u_sync (
		.clock(clock),
		.reset(reset),
		.din({gate_in, clk1_in, clk0_ext}),
		.level(sy)
	);

	// counter clock sources; counter two runs from counter one output
	// chained clock
	assign src = {s_ff.out[1], sy[1], s_ff.clk0_sel ? sy[0] : s_ff.int_clk};
	assign gate = sy[4:2];
	// count at end of clock pulse, trigger on gate rise
	assign tick = s_ff.clk_q & ~src;
	assign rise = gate & ~s_ff.gate_q;

	// apb phase and address decode
	assign acc = psel & penable;
	assign done = acc & s_ff.pready;
	assign wr_cyc = done & pwrite;
	assign ctr_hit = (paddr == `ICT_OFF_CNT0) | (paddr == `ICT_OFF_CNT1) |
		(paddr == `ICT_OFF_CNT2);
	assign ctrl_hit = (paddr == `ICT_OFF_CTRL);
	assign cs_hit = (paddr == `ICT_OFF_CSEL);
	assign cid = (paddr == `ICT_OFF_CNT1) ? 2'h1 : (paddr == `ICT_OFF_CNT2) ? 2'h2 : 2'h0;

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		logic [15:0] d1;
		logic [15:0] d2;
		logic [15:0] drel;
		logic [15:0] v;
		logic [1:0] k;
		logic [2:0] nm;
		logic commit;
		nxt_s = s_ff;
		d1 = '0;
		d2 = '0;
		drel = '0;
		v = '0;
		k = '0;
		nm = '0;
		commit = 1'b0;

		// internal 10 MHz clock from the system clock
		if (s_ff.div == HALF_M1)
		begin
			nxt_s.div = '0;
			nxt_s.int_clk = ~s_ff.int_clk;
		end
		else
			nxt_s.div = s_ff.div + 5'h1;

		for (int i = 0; i < `ICT_NCNT; i++)
		begin
			d1 = ict_dec(s_ff.cnt[i], s_ff.bcd[i]);
			d2 = ict_dec(d1, s_ff.bcd[i]);
			drel = ict_dec(s_ff.rel[i], s_ff.bcd[i]);
			nxt_s.clk_q[i] = src[i];
			nxt_s.gate_q[i] = gate[i];
			// a trigger waits for the next count clock; a new rise wins
			nxt_s.trig[i] = rise[i] | (s_ff.trig[i] & ~tick[i]);
			if (tick[i])
			begin
				unique case (s_ff.mode[i])
					`ICT_M0:
					begin
						// count while gated, high at zero
						if (s_ff.pend[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.pend[i] = 1'b0;
						end
						else if (gate[i])
						begin
							nxt_s.cnt[i] = d1;
							if (s_ff.cnt[i] == `ICT_CNT_ONE)
								nxt_s.out[i] = 1'b1;
						end
					end
					`ICT_M1:
					begin
						if (s_ff.trig[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.out[i] = 1'b0;
							nxt_s.pend[i] = 1'b0;
						end
						else if (!s_ff.out[i])
						begin
							nxt_s.cnt[i] = d1;
							if (s_ff.cnt[i] == `ICT_CNT_ONE)
								nxt_s.out[i] = 1'b1;
						end
					end
					`ICT_M2:
					begin
						// one low clock every n counts
						if (s_ff.pend[i] | s_ff.trig[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.out[i] = 1'b1;
							nxt_s.pend[i] = 1'b0;
						end
						else if (!gate[i])
							nxt_s.out[i] = 1'b1;
						else if (s_ff.cnt[i] == `ICT_CNT_ONE)
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.out[i] = 1'b1;
						end
						else
						begin
							nxt_s.cnt[i] = d1;
							if (s_ff.cnt[i] == `ICT_CNT_TWO)
								nxt_s.out[i] = 1'b0;
						end
					end
					`ICT_M3:
					begin
						// odd counts: high half one longer
						// step by two, reload each half-wave
						if (s_ff.pend[i] | s_ff.trig[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.out[i] = 1'b1;
							nxt_s.pend[i] = 1'b0;
						end
						else if (!gate[i])
							nxt_s.out[i] = 1'b1;
						else if (s_ff.cnt[i] == `ICT_CNT_TWO)
						begin
							nxt_s.out[i] = ~s_ff.out[i];
							if (s_ff.out[i] && s_ff.rel[i][0])
								nxt_s.cnt[i] = drel;
							else
								nxt_s.cnt[i] = s_ff.rel[i];
						end
						else
							nxt_s.cnt[i] = s_ff.cnt[i][0] ? d1 : d2;
					end
					`ICT_M4:
					begin
						if (!s_ff.out[i])
							nxt_s.out[i] = 1'b1;
						if (s_ff.pend[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.pend[i] = 1'b0;
						end
						else if (gate[i] && s_ff.arm[i])
						begin
							nxt_s.cnt[i] = d1;
							if (s_ff.cnt[i] == `ICT_CNT_ONE)
							begin
								nxt_s.out[i] = 1'b0;
								nxt_s.arm[i] = 1'b0;
							end
						end
					end
					`ICT_M5:
					begin
						// gate rise starts a full count
						if (!s_ff.out[i])
							nxt_s.out[i] = 1'b1;
						if (s_ff.trig[i])
						begin
							nxt_s.cnt[i] = s_ff.rel[i];
							nxt_s.arm[i] = 1'b1;
							nxt_s.pend[i] = 1'b0;
						end
						else if (s_ff.arm[i])
						begin
							nxt_s.cnt[i] = d1;
							if (s_ff.cnt[i] == `ICT_CNT_ONE)
							begin
								nxt_s.out[i] = 1'b0;
								nxt_s.arm[i] = 1'b0;
							end
						end
					end
				endcase
			end
		end

		// apb: one wait state, error on unmapped address
		nxt_s.pready = acc & ~s_ff.pready;
		nxt_s.pslverr = acc & ~s_ff.pready & ~(ctr_hit | ctrl_hit | cs_hit);

		// read data prepared in the first access cycle
		if (acc && !s_ff.pready)
		begin
			nxt_s.prdata = '0;
			if (ctr_hit)
			begin
				// held value wins over the live count
				v = s_ff.held[cid] ? s_ff.hold[cid] : s_ff.cnt[cid];
				unique case (s_ff.rw[cid])
					`ICT_RW_MSB: nxt_s.prdata[`ICT_LO] = v[`ICT_HI];
					`ICT_RW_LH: nxt_s.prdata[`ICT_LO] = s_ff.rd_hi[cid] ? v[`ICT_HI] : v[`ICT_LO];
					default: nxt_s.prdata[`ICT_LO] = v[`ICT_LO];
				endcase
			end
			else if (cs_hit)
			begin
				nxt_s.prdata[`ICT_CS_SEL] = s_ff.clk0_sel;
				nxt_s.prdata[`ICT_CS_OUT] = s_ff.out;
			end
		end

		if (done && !pwrite && ctr_hit)
		begin
			if (s_ff.rw[cid] == `ICT_RW_LH && !s_ff.rd_hi[cid])
				nxt_s.rd_hi[cid] = 1'b1;
			else
			begin
				nxt_s.rd_hi[cid] = 1'b0;
				nxt_s.held[cid] = 1'b0;
			end
		end

		// count writes through the byte order of the counter
		if (wr_cyc && ctr_hit)
		begin
			unique case (s_ff.rw[cid])
				`ICT_RW_LSB:
				begin
					nxt_s.rel[cid] = {8'h00, pwdata[`ICT_LO]};
					commit = 1'b1;
				end
				`ICT_RW_MSB:
				begin
					nxt_s.rel[cid] = {pwdata[`ICT_LO], 8'h00};
					commit = 1'b1;
				end
				`ICT_RW_LH:
				begin
					if (!s_ff.wr_hi[cid])
					begin
						nxt_s.rel[cid][`ICT_LO] = pwdata[`ICT_LO];
						nxt_s.wr_hi[cid] = 1'b1;
					end
					else
					begin
						nxt_s.rel[cid][`ICT_HI] = pwdata[`ICT_LO];
						nxt_s.wr_hi[cid] = 1'b0;
						commit = 1'b1;
					end
				end
				`ICT_RW_LATCH:
					commit = 1'b0;
			endcase
			if (commit)
			begin
				nxt_s.pend[cid] = 1'b1;
				// mode 5 stays idle until a gate rise arms it
				if (s_ff.mode[cid] != `ICT_M5)
					nxt_s.arm[cid] = 1'b1;
				// a new count drives mode 0 low
				if (s_ff.mode[cid] == `ICT_M0)
					nxt_s.out[cid] = 1'b0;
			end
		end

		if (wr_cyc && ctrl_hit)
		begin
			if (pwdata[`ICT_CW_SC] != `ICT_SC_RB)
			begin
				k = pwdata[`ICT_CW_SC];
				if (pwdata[`ICT_CW_RW] == `ICT_RW_LATCH)
				begin
					if (!s_ff.held[k])
					begin
						nxt_s.hold[k] = s_ff.cnt[k];
						nxt_s.held[k] = 1'b1;
					end
				end
				else
				begin
					// x1x folds onto modes 2 and 3
					nm = pwdata[`ICT_CW_MODE];
					if (nm[1])
						nm[2] = 1'b0;
					nxt_s.mode[k] = nm;
					nxt_s.rw[k] = pwdata[`ICT_CW_RW];
					nxt_s.bcd[k] = pwdata[`ICT_CW_BCD];
					nxt_s.out[k] = (nm != `ICT_M0);
					nxt_s.pend[k] = 1'b0;
					nxt_s.arm[k] = 1'b0;
					nxt_s.wr_hi[k] = 1'b0;
					nxt_s.rd_hi[k] = 1'b0;
					nxt_s.held[k] = 1'b0;
				end
			end
			else
			begin
				// read-back latches all selected counters at once
				for (int i = 0; i < `ICT_NCNT; i++)
				begin
					if (!pwdata[`ICT_RB_CNT_N] && pwdata[`ICT_RB_C0 + i] && !s_ff.held[i])
					begin
						nxt_s.hold[i] = s_ff.cnt[i];
						nxt_s.held[i] = 1'b1;
					end
				end
			end
		end

		// clock select register
		if (wr_cyc && cs_hit)
			nxt_s.clk0_sel = pwdata[`ICT_CS_SEL];

		// conversion start on each rising edge of counter two
		nxt_s.ad_start = nxt_s.out[2] & ~s_ff.out[2];
	end

	// state register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// outputs straight from the state register
	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign cnt_out = s_ff.out;
	assign ad_start = s_ff.ad_start;

	// ************************************************
	// assertions
	// ************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_m2_edge;
		tick[0] && gate[0] && !wr_cyc && s_ff.mode[0] == `ICT_M2 &&
			!s_ff.pend[0] && !s_ff.trig[0] && s_ff.cnt[0] == `ICT_CNT_TWO;
	endsequence

	sequence s_low_one;
		!cnt_out[0] && s_ff.cnt[0] == `ICT_CNT_ONE;
	endsequence

	a_mode2_low_pulse: assert property (s_m2_edge |=> s_low_one)
		else $error("mode 2 low pulse missing");
	a_mode0_load_low: assert property (
		wr_cyc && ctr_hit && cid == 2'h1 && s_ff.mode[1] == `ICT_M0 &&
		s_ff.rw[1] == `ICT_RW_LH && s_ff.wr_hi[1] |=> !cnt_out[1])
		else $error("mode 0 load left output high");
	a_mode1_trigger: assert property (
		tick[0] && s_ff.trig[0] && !wr_cyc && s_ff.mode[0] == `ICT_M1
		|=> !cnt_out[0] && s_ff.cnt[0] == s_ff.rel[0])
		else $error("mode 1 trigger did not start pulse");
	a_mode3_toggle: assert property (
		tick[1] && gate[1] && !wr_cyc && s_ff.mode[1] == `ICT_M3 &&
		!s_ff.pend[1] && !s_ff.trig[1] && s_ff.cnt[1] == `ICT_CNT_TWO
		|=> cnt_out[1] != $past(cnt_out[1]))
		else $error("mode 3 half-wave did not toggle");
	a_mode4_gate_hold: assert property (
		tick[1] && !gate[1] && !wr_cyc && s_ff.mode[1] == `ICT_M4 && !s_ff.pend[1]
		|=> $stable(s_ff.cnt[1]))
		else $error("mode 4 counted with gate low");
	a_chain_clock: assert property ($fell(s_ff.out[1]) |-> tick[2])
		else $error("counter two missed a clock");
	a_latch_hold: assert property (
		wr_cyc && ctrl_hit && pwdata[`ICT_CW_SC] == 2'h1 &&
		pwdata[`ICT_CW_RW] == `ICT_RW_LATCH && !s_ff.held[1]
		|=> s_ff.held[1] && s_ff.hold[1] == $past(s_ff.cnt[1]))
		else $error("latch did not capture count");
	a_ctrl_read_zero: assert property (done && !pwrite && ctrl_hit |-> prdata == '0)
		else $error("control location returned data");
	a_apb_one_wait: assert property (acc && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

endmodule

//--- include/ict_defines.svh
// constants of the interval counter timer: offsets, fields, codes, timing
// Functional notes
// - three independent presettable 16-bit down-counters
// - divisors 2 to 65,535; output rate is input rate over loaded value
// - counter one output clocks counter two; counter two output starts conversions
// - gate rising edge is a trigger; a positive clock pulse is one count
// - mode 0: load drives output low, counting runs, high at zero until reload
// - mode 1: output low after trigger, high at zero; early trigger restarts it
// - mode 2: divide by N, one clock low per N counts, stops with gate low
// - mode 3: square wave; odd N high (N+1)/2, low (N-1)/2 counts
// - mode 3: decrement by two each half-wave, reloading between halves
// - mode 4: output high, counting starts on load, one low period at zero
// - mode 4: low gate level holds the count
// - mode 5: rising gate starts full count, one low clock at terminal count
// - control byte: select 7:6, access 5:4, mode 3:1, format bit 0
// - select 00/01/10 picks counter 0/1/2, 11 is a read-back command
// - access 00 latch, 01 low byte, 10 high byte, 11 low then high
// - mode 000,001,x10,x11,100,101 give modes 0 to 5
// - format bit clear counts binary, set counts BCD
// - counter zero clock selectable: internal 10MHz or external pin
// - latch copies count to hold register; reads return it, counting goes on
// - low/high mode pairs accesses through a byte sequencing flip-flop
`ifndef ICT_DEFINES_SVH
`define ICT_DEFINES_SVH

// ************************************************
// register map, byte addresses on the apb bus
// ************************************************
`define ICT_OFF_CNT0 8'h00
`define ICT_OFF_CNT1 8'h04
`define ICT_OFF_CNT2 8'h08
`define ICT_OFF_CTRL 8'h0c
`define ICT_OFF_CSEL 8'h10

// ************************************************
// control byte fields and codes
// ************************************************
`define ICT_CW_SC 7:6
`define ICT_CW_RW 5:4
`define ICT_CW_MODE 3:1
`define ICT_CW_BCD 0
`define ICT_SC_RB 2'h3
`define ICT_RW_LATCH 2'h0
`define ICT_RW_LSB 2'h1
`define ICT_RW_MSB 2'h2
`define ICT_RW_LH 2'h3
`define ICT_RB_CNT_N 5
`define ICT_RB_C0 1
`define ICT_M0 3'h0
`define ICT_M1 3'h1
`define ICT_M2 3'h2
`define ICT_M3 3'h3
`define ICT_M4 3'h4
`define ICT_M5 3'h5

// ************************************************
// clock select register fields, data byte lanes
// ************************************************
`define ICT_CS_SEL 0
`define ICT_CS_OUT 6:4
`define ICT_LO 7:0
`define ICT_HI 15:8

// ************************************************
// counting constants and timing
// ************************************************
`define ICT_NCNT 3
`define ICT_CNT_ONE 16'h0001
`define ICT_CNT_TWO 16'h0002
`define ICT_BCD_MAX 4'h9
`define ICT_SYS_PERIOD_NS 5
`define ICT_INT_PERIOD_NS 100

`endif

//--- include/ict_pkg.sv
// types of the interval counter timer
package ict_pkg;

	// whole state of the timer top level
	typedef struct packed {
		logic [2:0][2:0] mode;
		logic [2:0][1:0] rw;
		logic [2:0] bcd;
		logic [2:0][15:0] cnt;
		logic [2:0][15:0] rel;
		logic [2:0][15:0] hold;
		logic [2:0] held;
		logic [2:0] out;
		logic [2:0] pend;
		logic [2:0] arm;
		logic [2:0] trig;
		logic [2:0] wr_hi;
		logic [2:0] rd_hi;
		logic [2:0] clk_q;
		logic [2:0] gate_q;
		logic [4:0] div;
		logic int_clk;
		logic clk0_sel;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic ad_start;
	} ict_state_t;

endpackage

//--- design/ict_sync.sv
// three flip-flop input synchroniser with agreement filter
module ict_sync #(
	parameter int W = 1
) (
	input wire logic clock, // system clock
	input wire logic reset, // async reset, active high
	input wire logic [W-1:0] din, // asynchronous pins
	output logic [W-1:0] level // filtered level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} ict_sync_t;

	ict_sync_t s_ff;
	ict_sync_t nxt_s;

	// shift chain; level follows once stages two and three agree
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.s1 = din;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		for (int i = 0; i < W; i++)
		begin
			if (s_ff.s2[i] == s_ff.s3[i])
				nxt_s.lvl[i] = s_ff.s3[i];
		end
	end

	// state register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign level = s_ff.lvl;

endmodule

//--- tb/ict_far_side.sv
// far-side model: counter clock pins, gate pins, conversion start tally
module ict_far_side (
	input wire logic clock, // system clock
	input wire logic reset, // async reset, active high
	input wire logic ad_start, // conversion start pulse
	output logic clk0_ext, // external clock of counter zero
	output logic clk1_in, // clock pin of counter one
	output logic [2:0] gate_in // gate pins of the counters
);
	timeunit 1ns;
	timeprecision 100ps;

	int starts = 0;

	// ****************************************
	// conversion start tally
	// ****************************************
	always @(posedge clock or posedge reset)
	begin
		if (reset)
			starts <= 0;
		else if (ad_start)
			starts <= starts + 1;
	end

	// pins idle low
	initial
	begin
		clk0_ext = 1'b0;
		clk1_in = 1'b0;
		gate_in = 3'h0;
	end

	// ****************************************
	// pin drivers
	// ****************************************
	// positive pulses, 100 ns period, clock stands between bursts
	task automatic pulse(input int pin, input int n);
		repeat (n)
		begin
			@(posedge clock);
			clk0_ext <= (pin == 0);
			clk1_in <= (pin == 1);
			repeat (10) @(posedge clock);
			clk0_ext <= 1'b0;
			clk1_in <= 1'b0;
			repeat (9) @(posedge clock);
		end
	endtask

	// gate level change, a rise is a trigger
	task automatic set_gate(input int g, input logic v);
		@(posedge clock);
		gate_in[g] <= v;
		repeat (6) @(posedge clock);
	endtask
endmodule

//--- tb/ict_timer_tb_top.sv
// self-checking testbench of the interval counter timer
module ict_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock, reset, psel, penable, pwrite, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, clk0_ext, clk1_in, ad_start;
	logic [2:0] gate_in, cnt_out, prev_out;
	logic [15:0] v, w;
	int failures = 0;
	int comparisons = 0;
	int falls0 = 0;
	int falls1 = 0;
	int n0, s0;

	ict_timer uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clk0_ext(clk0_ext), .clk1_in(clk1_in),
		.gate_in(gate_in), .cnt_out(cnt_out), .ad_start(ad_start));

	ict_far_side far (.clock(clock), .reset(reset), .ad_start(ad_start),
		.clk0_ext(clk0_ext), .clk1_in(clk1_in), .gate_in(gate_in));

	// 200 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// tally of falling output edges
	always @(posedge clock)
	begin
		prev_out <= cnt_out;
		if (prev_out[0] && !cnt_out[0])
			falls0 <= falls0 + 1;
		if (prev_out[1] && !cnt_out[1])
			falls1 <= falls1 + 1;
	end

	// ****************************************
	// bus and compare tasks
	// ****************************************
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// low byte then high byte
	task automatic wr16(input logic [7:0] a, input logic [15:0] val);
		apb(1'b1, a, val[7:0]);
		apb(1'b1, a, val[15:8]);
		repeat (4) @(posedge clock);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] val);
		apb(1'b0, a, 8'h00);
		val[7:0] = rd[7:0];
		apb(1'b0, a, 8'h00);
		val[15:8] = rd[7:0];
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task report_and_stop;
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#60us;
		failures++;
		report_and_stop;
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		prev_out = 3'h0;
		reset = 1'b1;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		// reset state, write-only control, unmapped place
		apb(1'b0, 8'h10, 8'h00);
		chk(rd, 32'h00000000);
		apb(1'b0, 8'h0c, 8'h00);
		chk(rd, 32'h00000000);
		apb(1'b0, 8'h14, 8'h00);
		chk({31'h0, er}, 32'h00000001);
		// mode 0 on counter one, count 5
		far.set_gate(1, 1'b1);
		apb(1'b1, 8'h0c, 8'h70);
		wr16(8'h04, 16'h0005);
		chk({31'h0, cnt_out[1]}, 32'h00000000);
		far.pulse(1, 3);
		chk({31'h0, cnt_out[1]}, 32'h00000000);
		far.pulse(1, 3);
		chk({31'h0, cnt_out[1]}, 32'h00000001);
		far.pulse(1, 2);
		chk({31'h0, cnt_out[1]}, 32'h00000001);
		// latch snapshot while counting goes on
		apb(1'b1, 8'h0c, 8'h70);
		wr16(8'h04, 16'h1234);
		far.pulse(1, 2);
		rd16(8'h04, v);
		chk({24'h0, v[15:8]}, 32'h00000012);
		apb(1'b1, 8'h0c, 8'h40);
		far.pulse(1, 2);
		rd16(8'h04, w);
		chk({16'h0, w}, {16'h0, v});
		rd16(8'h04, w);
		chk({16'h0, w}, {16'h0, v - 16'h0002});
		// mode 4, low byte only, gate holds the count
		far.set_gate(1, 1'b0);
		apb(1'b1, 8'h0c, 8'h58);
		apb(1'b1, 8'h04, 8'h03);
		n0 = falls1;
		far.pulse(1, 6);
		chk(32'(falls1 - n0), 32'h00000000);
		far.set_gate(1, 1'b1);
		far.pulse(1, 6);
		chk(32'(falls1 - n0), 32'h00000001);
		// mode 2 on counter zero from the external pin
		apb(1'b1, 8'h10, 8'h01);
		apb(1'b0, 8'h10, 8'h00);
		chk({31'h0, rd[0]}, 32'h00000001);
		far.set_gate(0, 1'b1);
		apb(1'b1, 8'h0c, 8'h34);
		wr16(8'h00, 16'h0003);
		n0 = falls0;
		far.pulse(0, 14);
		chk(32'(falls0 - n0), 32'h00000004);
		// internal 10 MHz source, 20 input periods
		apb(1'b1, 8'h10, 8'h00);
		n0 = falls0;
		repeat (400) @(posedge clock);
		chk({31'h0, (falls0 - n0) >= 6 && (falls0 - n0) <= 7}, 32'h00000001);
		// counter one square wave clocks counter two
		far.set_gate(2, 1'b1);
		apb(1'b1, 8'h0c, 8'h76);
		wr16(8'h04, 16'h0004);
		apb(1'b1, 8'h0c, 8'hb4);
		wr16(8'h08, 16'h0002);
		repeat (6) @(posedge clock);
		n0 = falls1;
		s0 = far.starts;
		far.pulse(1, 17);
		chk(32'(falls1 - n0), 32'h00000004);
		chk(32'(far.starts - s0), 32'h00000001);
		// mode 1 one-shot on counter zero from the external pin, retriggered
		apb(1'b1, 8'h10, 8'h01);
		far.set_gate(0, 1'b0);
		apb(1'b1, 8'h0c, 8'h12);
		apb(1'b1, 8'h00, 8'h03);
		far.set_gate(0, 1'b1);
		far.pulse(0, 3);
		chk({31'h0, cnt_out[0]}, 32'h00000000);
		far.set_gate(0, 1'b0);
		far.set_gate(0, 1'b1);
		far.pulse(0, 3);
		chk({31'h0, cnt_out[0]}, 32'h00000000);
		far.pulse(0, 1);
		chk({31'h0, cnt_out[0]}, 32'h00000001);
		// mode 5 waits for a gate rise, then one low clock
		apb(1'b1, 8'h0c, 8'h1a);
		apb(1'b1, 8'h00, 8'h02);
		n0 = falls0;
		far.pulse(0, 2);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h00000000);
		far.set_gate(0, 1'b0);
		far.set_gate(0, 1'b1);
		far.pulse(0, 3);
		chk(32'(falls0 - n0), 32'h00000001);
		far.pulse(0, 1);
		chk({31'h0, cnt_out[0]}, 32'h00000001);
		// bcd count and read-back latch of counter zero
		apb(1'b1, 8'h0c, 8'h11);
		apb(1'b1, 8'h00, 8'h10);
		far.pulse(0, 2);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h00000009);
		apb(1'b1, 8'h0c, 8'hc2);
		far.pulse(0, 1);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h00000009);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h00000008);
		report_and_stop;
	end
endmodule
